// ===== hw/cpr_flags.sv
// zero, half carry and carry results of one operation
`timescale 1ns/1ps
module cpr_flags
  import cpr_pkg::*;
(
  input  cpr_pkg::cpr_alu_type alu_i, // operation seen by the flags
  input  wire logic            cy_i,  // present carry
  output logic                 z_o,   // zero result
  output logic                 ac_o,  // half carry
  output logic                 cy_o   // new carry
);
  logic [8:0] sum;

  always_comb
  begin
    sum = alu_i.sub ? ({1'b0, alu_i.a} - {1'b0, alu_i.b})
                    : ({1'b0, alu_i.a} + {1'b0, alu_i.b});
    z_o = alu_i.w16 ? (alu_i.result == 16'h0000)
                    : (alu_i.result[7:0] == 8'h00);
    // bit 4 of a^b^sum is the carry into or borrow from bit 4
    ac_o = alu_i.a[4] ^ alu_i.b[4] ^ sum[4];
    case (alu_i.cy_src)
      CPR_CY_ARITH: cy_o = sum[8];
      CPR_CY_SHIFT: cy_o = alu_i.cy_in;
      CPR_CY_BIT:   cy_o = alu_i.cy_in;
      default:      cy_o = cy_i;
    endcase
  end
endmodule : cpr_flags

// ===== hw/cpr_gpr_mem.sv
// general register storage: four banks of eight bytes, registered reads
`timescale 1ns/1ps
module cpr_gpr_mem
#(
  parameter int DEPTH = 32
)
(
  input  wire logic        clock_i, // core clock
  input  wire logic        cwr_i,   // core write
  input  wire logic        cw16_i,  // core write is a pair
  input  wire logic [4:0]  cwa_i,   // core write byte address
  input  wire logic [15:0] cwd_i,   // core write data
  input  wire logic [4:0]  cra_i,   // core read byte address
  output logic      [15:0] crd_o,   // core read data, high:low
  input  wire logic        bwr_i,   // bus write
  input  wire logic [4:0]  ba_i,    // bus byte address
  input  wire logic [7:0]  bwd_i,   // bus write data
  output logic      [7:0]  brd_o    // bus read data
);
  logic [7:0] mem_q [DEPTH];

  // bus first so a core write to the same byte wins
  always_ff @(posedge clock_i)
  begin
    if (bwr_i)
      mem_q[ba_i] <= bwd_i;
    if (cwr_i)
    begin
      mem_q[cwa_i] <= cwd_i[7:0];
      if (cw16_i)
        mem_q[cwa_i | 5'h01] <= cwd_i[15:8];
    end
  end

  always_ff @(posedge clock_i)
  begin
    crd_o <= {mem_q[cra_i | 5'h01], mem_q[cra_i]};
    brd_o <= mem_q[ba_i];
  end
endmodule : cpr_gpr_mem

// ===== hw/cpr_map.svh
// constants and register addresses of the processor register set
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH
`define CPR_PSW_RESET   8'h06
`define CPR_ES_RESET    4'hf
`define CPR_CS_RESET    4'h0
`define CPR_PC_UP_RESET 4'h0
`define CPR_PSW_IE      7
`define CPR_PSW_Z       6
`define CPR_PSW_BANK_SELECT_HIGH    5
`define CPR_PSW_AC      4
`define CPR_PSW_BANK_SELECT_LOW    3
`define CPR_PSW_SERVICE_LEVEL_HIGH    2
`define CPR_PSW_SERVICE_LEVEL_LOW    1
`define CPR_PSW_CY      0
`define CPR_NEAR_PAGE   4'hf
`define CPR_GPR_BASE    20'hffee0
`define CPR_GPR_LAST    20'hffeff
`define CPR_ADR_PCL     20'hffff0
`define CPR_ADR_PCM     20'hffff1
`define CPR_ADR_PCH     20'hffff2
`define CPR_ADR_SPL     20'hffff8
`define CPR_ADR_SPH     20'hffff9
`define CPR_ADR_PSW     20'hffffa
`define CPR_ADR_CS      20'hffffc
`define CPR_ADR_ES      20'hffffd
`endif

// ===== hw/cpr_pkg.sv
// types shared by the processor register set
package cpr_pkg;
  typedef struct packed {
    logic       ie;
    logic       z;
    logic       bank_select_high;
    logic       ac;
    logic       bank_select_low;
    logic [1:0] isp;
    logic       cy;
  } cpr_psw_type;

  typedef struct packed {
    logic        fetch;
    logic [2:0]  ilen;
    logic        branch;
    logic        br_regdir;
    logic [19:0] br_target;
    logic        irq_off;
    logic        irq_on;
    logic        irq_ack;
    logic [1:0]  ack_level;
    logic        bank_sw;
    logic [1:0]  bank;
    logic        psw_restore;
    logic [7:0]  psw_data;
    logic        push;
    logic        pop;
    logic        push_status;
    logic        sp_load;
    logic [15:0] sp_data;
  } cpr_seq_type;

  typedef enum logic [1:0] {
    CPR_CY_ARITH = 2'b00,
    CPR_CY_SHIFT = 2'b01,
    CPR_CY_BIT   = 2'b10,
    CPR_CY_KEEP  = 2'b11
  } cpr_cysrc_type;

  typedef struct packed {
    logic          z_en;
    logic          ac_en;
    cpr_cysrc_type cy_src;
    logic          sub;
    logic [7:0]    a;
    logic [7:0]    b;
    logic [15:0]   result;
    logic          w16;
    logic          cy_in;
  } cpr_alu_type;

  typedef struct packed {
    logic        wr;
    logic        w16;
    logic [2:0]  widx;
    logic [15:0] wdata;
    logic        r16;
    logic [2:0]  ridx;
  } cpr_gpr_type;

  typedef struct packed {
    logic       es_wr;
    logic       cs_wr;
    logic [3:0] data;
  } cpr_seg_type;
endpackage : cpr_pkg

// ===== hw/cpr_regs.sv
// processor register set: counter, status, stack, segments, banks
`timescale 1ns/1ps
`include "cpr_map.svh"
module cpr_regs
  import cpr_pkg::*;
(
  input  wire logic             clock_i,  // core clock
  input  wire logic             nrst_i,   // sync reset, active low
  input  wire logic [7:0]       vec_lo_i, // reset vector byte at 0000H
  input  wire logic [7:0]       vec_hi_i, // reset vector byte at 0001H
  input  cpr_pkg::cpr_seq_type  seq_i,    // sequencer commands
  input  cpr_pkg::cpr_alu_type  alu_i,    // flag update request
  input  cpr_pkg::cpr_gpr_type  gpr_i,    // register access
  input  cpr_pkg::cpr_seg_type  seg_i,    // segment writes
  input  wire logic [15:0]      daddr_i,  // 16-bit data address
  input  wire logic             use_es_i, // segmented data access
  input  wire logic             req_i,    // maskable request pending
  input  wire logic             masked_i, // request source masked
  input  wire logic [1:0]       prio_i,   // request priority, 0 highest
  input  wire logic [19:0]      addr_i,   // bus address
  input  wire logic [7:0]       wdata_i,  // bus write data
  input  wire logic             wr_i,     // bus write strobe
  input  wire logic             rd_i,     // bus read strobe
  output logic      [7:0]       rdata_o,  // bus read data
  output logic      [19:0]      pc_o,     // program counter
  output cpr_pkg::cpr_psw_type  psw_o,    // status word
  output logic      [15:0]      sp_o,     // stack pointer
  output logic      [19:0]      stk_adr_o,// stack byte address
  output logic                  save_psw_o,// status goes onto stack
  output logic                  sp_bad_o, // stack used before load
  output logic      [3:0]       es_o,     // data segment
  output logic      [3:0]       cs_o,     // code segment
  output logic      [19:0]      dadr_o,   // full data address
  output logic      [15:0]      grd_o,    // register read data
  output logic                  ack_ok_o  // request may be acknowledged
);
  logic [19:0]  pc_q;
  cpr_psw_type  psw_q;
  logic [15:0]  sp_q;
  logic         sp_ok_q;
  logic         sp_bad_q;
  logic [3:0]   es_q;
  logic [3:0]   cs_q;
  logic [7:0]   spr_q;
  logic         gsel_q;
  logic [15:0]  gpr_rd;
  logic [7:0]   bus_gpr;
  logic [4:0]   bank_base;
  logic [4:0]   bus_ofs;
  logic         bus_gpr_hit;
  logic         f_z;
  logic         f_ac;
  logic         f_cy;

  // bank 3 sits lowest, bank 0 highest, eight bytes each
  assign bank_base = {~{psw_q.bank_select_high, psw_q.bank_select_low}, 3'h0};
  assign bus_gpr_hit = (addr_i >= `CPR_GPR_BASE) &&
                       (addr_i <= `CPR_GPR_LAST);
  assign bus_ofs = addr_i[4:0];

  cpr_gpr_mem #(
    .DEPTH (32)
  ) u_mem (
    .clock_i (clock_i),
    .cwr_i   (gpr_i.wr),
    .cw16_i  (gpr_i.w16),
    .cwa_i   (bank_base | {2'h0, gpr_i.widx}),
    .cwd_i   (gpr_i.wdata),
    .cra_i   (bank_base | {2'h0, gpr_i.ridx}),
    .crd_o   (gpr_rd),
    .bwr_i   (wr_i && bus_gpr_hit),
    .ba_i    (bus_ofs),
    .bwd_i   (wdata_i),
    .brd_o   (bus_gpr)
  );

  // a byte read returns the addressed byte in the low lane
  logic gr16_q;
  logic grodd_q;

  always_ff @(posedge clock_i)
  begin
    gr16_q  <= gpr_i.r16;
    grodd_q <= gpr_i.ridx[0];
  end

  assign grd_o = gr16_q ? gpr_rd
               : {8'h00, grodd_q ? gpr_rd[15:8] : gpr_rd[7:0]};

  cpr_flags u_flags (
    .alu_i (alu_i),
    .cy_i  (psw_q.cy),
    .z_o   (f_z),
    .ac_o  (f_ac),
    .cy_o  (f_cy)
  );

  // program counter
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      pc_q <= {`CPR_PC_UP_RESET, vec_hi_i, vec_lo_i};
    else if (seq_i.branch)
      pc_q <= seq_i.br_regdir ? {cs_q, seq_i.br_target[15:0]}
                              : seq_i.br_target;
    else if (seq_i.fetch)
      pc_q <= pc_q + {17'h00000, seq_i.ilen};
  end

  // status word; later statements win, so restore beats the rest
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      psw_q <= `CPR_PSW_RESET;
    else
    begin
      if (wr_i && addr_i == `CPR_ADR_PSW)
        psw_q <= wdata_i;
      if (alu_i.z_en)
        psw_q.z <= f_z;
      if (alu_i.ac_en)
        psw_q.ac <= f_ac;
      psw_q.cy <= f_cy;
      if (seq_i.bank_sw)
        {psw_q.bank_select_high, psw_q.bank_select_low} <= seq_i.bank;
      if (seq_i.irq_on)
        psw_q.ie <= 1'b1;
      if (seq_i.irq_off)
        psw_q.ie <= 1'b0;
      if (seq_i.irq_ack)
      begin
        psw_q.ie  <= 1'b0;
        psw_q.isp <= seq_i.ack_level;
      end
      if (seq_i.psw_restore)
        psw_q <= seq_i.psw_data;
    end
  end

  // no reset on the pointer itself; a flag tracks that it was loaded
  always_ff @(posedge clock_i)
  begin
    if (seq_i.sp_load)
      sp_q <= seq_i.sp_data;
    else if (wr_i && addr_i == `CPR_ADR_SPL)
      sp_q <= {sp_q[15:8], wdata_i};
    else if (wr_i && addr_i == `CPR_ADR_SPH)
      sp_q <= {wdata_i, sp_q[7:0]};
    else if (seq_i.push)
      sp_q <= sp_q - 16'h0001;
    else if (seq_i.pop)
      sp_q <= sp_q + 16'h0001;
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      sp_ok_q <= 1'b0;
    else if (seq_i.sp_load || (wr_i && addr_i == `CPR_ADR_SPH))
      sp_ok_q <= 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      sp_bad_q <= 1'b0;
    else
      sp_bad_q <= (seq_i.push || seq_i.pop) && !sp_ok_q;
  end

  // segments
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      es_q <= `CPR_ES_RESET;
      cs_q <= `CPR_CS_RESET;
    end
    else
    begin
      if (wr_i && addr_i == `CPR_ADR_ES)
        es_q <= wdata_i[3:0];
      if (wr_i && addr_i == `CPR_ADR_CS)
        cs_q <= wdata_i[3:0];
      if (seg_i.es_wr)
        es_q <= seg_i.data;
      if (seg_i.cs_wr)
        cs_q <= seg_i.data;
    end
  end

  // bus read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      gsel_q <= 1'b0;
    else
      gsel_q <= rd_i && bus_gpr_hit;
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      spr_q <= 8'h00;
    else if (rd_i)
    begin
      case (addr_i)
        `CPR_ADR_PCL: spr_q <= pc_q[7:0];
        `CPR_ADR_PCM: spr_q <= pc_q[15:8];
        `CPR_ADR_PCH: spr_q <= {4'h0, pc_q[19:16]};
        `CPR_ADR_SPL: spr_q <= sp_ok_q ? sp_q[7:0] : 8'h00;
        `CPR_ADR_SPH: spr_q <= sp_ok_q ? sp_q[15:8] : 8'h00;
        `CPR_ADR_PSW: spr_q <= psw_q;
        `CPR_ADR_ES:  spr_q <= {4'h0, es_q};
        `CPR_ADR_CS:  spr_q <= {4'h0, cs_q};
        default:      spr_q <= 8'h00;
      endcase
    end
    else
      spr_q <= 8'h00;
  end

  assign rdata_o = gsel_q ? bus_gpr : spr_q;

  // outputs
  assign pc_o       = pc_q;
  assign psw_o      = psw_q;
  assign sp_o       = sp_ok_q ? sp_q : 16'h0000;
  assign sp_bad_o   = sp_bad_q;
  assign es_o       = es_q;
  assign cs_o       = cs_q;
  // the stack word sits in the top page of internal RAM
  assign stk_adr_o  = {`CPR_NEAR_PAGE,
                       seq_i.push ? sp_o - 16'h0001 : sp_o};
  assign save_psw_o = seq_i.push_status || seq_i.irq_ack;
  assign dadr_o     = use_es_i ? {es_q, daddr_i}
                               : {`CPR_NEAR_PAGE, daddr_i};
  // a larger number means a lower priority
  assign ack_ok_o   = psw_q.ie && req_i && !masked_i &&
                      (prio_i <= psw_q.isp);

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  a_pc_seq_adv: assert property (seq_i.fetch && !seq_i.branch
    |=> pc_q == $past(pc_q) + {17'h00000, $past(seq_i.ilen)})
    else $error("pc did not advance by length");
  a_pc_branch: assert property (seq_i.branch && !seq_i.br_regdir
    |=> pc_q == $past(seq_i.br_target))
    else $error("pc missed branch target");
  a_pc_reset_vec: assert property ($rose(nrst_i)
    |-> pc_q == {4'h0, $past(vec_hi_i), $past(vec_lo_i)})
    else $error("pc not loaded from vector");
  a_psw_reset: assert property ($rose(nrst_i)
    |-> psw_q == 8'h06 && es_q == 4'hf && cs_q == 4'h0)
    else $error("status or segment reset value wrong");
  a_gate_refuse: assert property (!psw_q.ie |-> !ack_ok_o)
    else $error("ack allowed with gate closed");
  a_prio_refuse: assert property (prio_i > psw_q.isp |-> !ack_ok_o)
    else $error("ack allowed below service level");
  a_ie_ack_clear: assert property (seq_i.irq_ack && !seq_i.psw_restore
    |=> !psw_q.ie ##1 $stable(psw_q.isp) || seq_i.psw_restore ||
        seq_i.irq_ack || $past(wr_i))
    else $error("gate not cleared on acknowledge");
  a_bank_switch: assert property (seq_i.bank_sw && !seq_i.psw_restore
    && !wr_i |=> {psw_q.bank_select_high, psw_q.bank_select_low} == $past(seq_i.bank))
    else $error("bank select not written");
  // the pointer holds no defined value until loaded, so only check then
  a_sp_predec: assert property (seq_i.push && !seq_i.sp_load && !wr_i
    && sp_ok_q
    |-> stk_adr_o[15:0] == sp_o - 16'h0001 ##1 sp_q == $past(sp_q)
    - 16'h0001)
    else $error("stack pointer not decremented before save");
  a_sp_unloaded: assert property (seq_i.push && !sp_ok_q
    |=> sp_bad_o)
    else $error("stack use before load not flagged");
  a_near_page: assert property (!use_es_i
    |-> dadr_o[19:16] == 4'hf)
    else $error("plain data address left top page");
  a_zero_flag: assert property (alu_i.z_en && !alu_i.w16 &&
    alu_i.result[7:0] == 8'h00 && !seq_i.psw_restore && !wr_i
    |=> psw_q.z)
    else $error("zero flag not set");

  a_sp_postinc: assert property (seq_i.pop && !seq_i.push &&
    !seq_i.sp_load && !wr_i && sp_ok_q
    |=> sp_q == $past(sp_q) + 16'h0001)
    else $error("stack pointer not incremented after restore");
  a_ack_open: assert property (psw_q.ie && req_i && !masked_i &&
    prio_i <= psw_q.isp |-> ack_ok_o)
    else $error("ack refused with gate open and level met");
  a_irq_on_set: assert property (seq_i.irq_on && !seq_i.irq_off &&
    !seq_i.irq_ack && !seq_i.psw_restore |=> psw_q.ie)
    else $error("gate not set by irq on");
  a_save_psw: assert property (seq_i.irq_ack |-> save_psw_o)
    else $error("status not saved on acknowledge");
  a_psw_restore: assert property (seq_i.psw_restore
    |=> psw_q == $past(seq_i.psw_data))
    else $error("status not restored");
  a_seg_upper: assert property (rd_i && addr_i == `CPR_ADR_ES
    |=> rdata_o[7:4] == 4'h0)
    else $error("segment upper bits not zero");
  a_seg_addr: assert property (use_es_i
    |-> dadr_o == {es_q, daddr_i})
    else $error("segmented address not built from data segment");

  c_irq_ack: cover property (ack_ok_o ##1 seq_i.irq_ack);
  c_regdir: cover property (seq_i.branch && seq_i.br_regdir);
  c_bank_read: cover property (seq_i.bank_sw ##1 gpr_i.r16);
  c_push_pop: cover property (seq_i.push ##[1:20] seq_i.pop);
  c_bus_gpr: cover property (rd_i && bus_gpr_hit);
endmodule : cpr_regs

// ===== tb/cpr_core_model.sv
// core-side model: issues sequencer, flag, register and segment requests
`timescale 1ns/1ps
module cpr_core_model
(
  input  wire logic           clock_i, // core clock
  output cpr_pkg::cpr_seq_type seq_o,  // sequencer commands
  output cpr_pkg::cpr_alu_type alu_o,  // flag requests
  output cpr_pkg::cpr_gpr_type gpr_o,  // register access
  output cpr_pkg::cpr_seg_type seg_o   // segment writes
);
  import cpr_pkg::*;

  // an all-zero flag request would rewrite the carry, so idle keeps it
  function automatic cpr_alu_type idle_alu();
    cpr_alu_type r;
    r = '0;
    r.cy_src = CPR_CY_KEEP;
    return r;
  endfunction : idle_alu

  initial
  begin
    seq_o = '0;
    alu_o = idle_alu();
    gpr_o = '0;
    seg_o = '0;
  end

  task automatic put(input cpr_seq_type s, input cpr_alu_type a,
                     input cpr_gpr_type g, input cpr_seg_type e);
    @(posedge clock_i);
    seq_o <= s;
    alu_o <= a;
    gpr_o <= g;
    seg_o <= e;
    #1;
  endtask : put

  task automatic idle();
    @(posedge clock_i);
    seq_o <= '0;
    alu_o <= idle_alu();
    gpr_o <= '0;
    seg_o <= '0;
    #1;
  endtask : idle
endmodule : cpr_core_model

// ===== tb/cpu_processor_registers_tb_top.sv
// self-checking bench for the processor register set
`timescale 1ns/1ps
module cpu_processor_registers_tb_top;
  import cpr_pkg::*;
  logic        clock_i  = 1'b0;
  logic        nrst_i   = 1'b0;
  logic [7:0]  vec_lo_i = 8'h21;
  logic [7:0]  vec_hi_i = 8'h43;
  logic [19:0] addr_i   = '0;
  logic [7:0]  wdata_i  = '0;
  logic        wr_i     = 1'b0;
  logic        rd_i     = 1'b0;
  logic [15:0] daddr_i  = '0;
  logic        use_es_i = 1'b0;
  logic        req_i    = 1'b0;
  logic        masked_i = 1'b0;
  logic [1:0]  prio_i   = '0;
  logic [7:0]  rdata_o;
  logic [19:0] pc_o, stk_adr_o, dadr_o;
  cpr_psw_type psw_o;
  logic [15:0] sp_o, grd_o;
  logic [3:0]  es_o, cs_o;
  logic        save_psw_o, ack_ok_o, sp_bad_o;
  cpr_seq_type seq, s;
  cpr_alu_type alu, a, ka;
  cpr_gpr_type gpr, g;
  cpr_seg_type seg, e;
  int          num_errors = 0;
  int          checks     = 0;
  logic [7:0]  d;

  always #50 clock_i = ~clock_i;

  cpr_core_model cpr_core_model_i (.clock_i(clock_i), .seq_o(seq),
    .alu_o(alu), .gpr_o(gpr), .seg_o(seg));

  cpr_regs cpr_regs_i (.clock_i(clock_i), .nrst_i(nrst_i),
    .vec_lo_i(vec_lo_i), .vec_hi_i(vec_hi_i), .seq_i(seq), .alu_i(alu),
    .gpr_i(gpr), .seg_i(seg), .daddr_i(daddr_i), .use_es_i(use_es_i),
    .req_i(req_i), .masked_i(masked_i), .prio_i(prio_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pc_o(pc_o), .psw_o(psw_o), .sp_o(sp_o),
    .stk_adr_o(stk_adr_o), .save_psw_o(save_psw_o), .sp_bad_o(sp_bad_o),
    .es_o(es_o), .cs_o(cs_o), .dadr_o(dadr_o), .grd_o(grd_o),
    .ack_ok_o(ack_ok_o));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // drivers wait 1 ns past their edge so outputs have settled here
  task automatic chk(input string n, input logic [19:0] x,
                     input logic [19:0] y);
    checks++;
    if (y !== x)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, y);
    end
  endtask : chk

  task automatic bwr(input logic [19:0] ad, input logic [7:0] v);
    @(posedge clock_i);
    addr_i  <= ad;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
    #1;
  endtask : bwr

  task automatic rchk(input logic [19:0] ad, input logic [7:0] x);
    @(posedge clock_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    chk("rdata", {12'h000, x}, {12'h000, rdata_o});
  endtask : rchk

  task automatic run(input cpr_seq_type q, input cpr_alu_type u,
                     input cpr_gpr_type r, input cpr_seg_type t);
    cpr_core_model_i.put(q, u, r, t);
    cpr_core_model_i.idle();
  endtask : run

  task automatic sq(input cpr_seq_type q);
    run(q, ka, '0, '0);
  endtask : sq

  task automatic pins(input logic r, input logic m, input logic [1:0] p);
    @(posedge clock_i);
    req_i    <= r;
    masked_i <= m;
    prio_i   <= p;
    #1;
  endtask : pins

  initial
  begin
    #(100 * 5000);
    num_errors++;
    wrap_up();
  end

  initial
  begin
    ka = '0;
    ka.cy_src = CPR_CY_KEEP;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    #1;
    chk("pc", 20'h04321, pc_o);
    chk("psw", 20'h06, psw_o);
    chk("es", 20'hf, es_o);
    chk("cs", 20'h0, cs_o);
    rchk(20'hffffd, 8'h0f);
    rchk(20'hffffa, 8'h06);
    $display("test reset done");
    s = '0;
    s.fetch = 1'b1;
    s.ilen = 3'h3;
    sq(s);
    chk("pc", 20'h04324, pc_o);
    s = '0;
    s.branch = 1'b1;
    s.br_target = 20'h5a5a5;
    sq(s);
    chk("pc", 20'h5a5a5, pc_o);
    e = '0;
    e.cs_wr = 1'b1;
    e.data = 4'h7;
    run('0, ka, '0, e);
    chk("cs", 20'h7, cs_o);
    s.br_regdir = 1'b1;
    s.br_target = 20'h0beef;
    sq(s);
    chk("pc", 20'h7beef, pc_o);
    $display("test counter done");
    pins(1'b1, 1'b0, 2'h3);
    chk("ack", 20'h0, ack_ok_o);
    s = '0;
    s.irq_on = 1'b1;
    sq(s);
    chk("psw", 20'h86, psw_o);
    chk("ack", 20'h1, ack_ok_o);
    pins(1'b1, 1'b1, 2'h3);
    chk("ack", 20'h0, ack_ok_o);
    pins(1'b1, 1'b0, 2'h3);
    s = '0;
    s.irq_ack = 1'b1;
    s.ack_level = 2'h1;
    cpr_core_model_i.put(s, ka, '0, '0);
    chk("save", 20'h1, save_psw_o);
    cpr_core_model_i.idle();
    chk("psw", 20'h02, psw_o);
    s = '0;
    s.irq_on = 1'b1;
    sq(s);
    pins(1'b1, 1'b0, 2'h2);
    chk("ack", 20'h0, ack_ok_o);
    pins(1'b1, 1'b0, 2'h1);
    chk("ack", 20'h1, ack_ok_o);
    s = '0;
    s.irq_off = 1'b1;
    sq(s);
    chk("psw", 20'h02, psw_o);
    pins(1'b0, 1'b0, 2'h0);
    s = '0;
    s.bank_sw = 1'b1;
    s.bank = 2'h2;
    sq(s);
    chk("psw", 20'h22, psw_o);
    s = '0;
    s.psw_restore = 1'b1;
    s.psw_data = 8'h5b;
    sq(s);
    chk("psw", 20'h5b, psw_o);
    $display("test status done");
    a = '0;
    a.z_en = 1'b1;
    a.ac_en = 1'b1;
    a.a = 8'h0f;
    a.b = 8'h01;
    a.result = 16'h0010;
    run('0, a, '0, '0);
    chk("psw", 20'h1a, psw_o);
    a.a = 8'hff;
    a.result = 16'h0000;
    run('0, a, '0, '0);
    chk("psw", 20'h5b, psw_o);
    a.sub = 1'b1;
    a.a = 8'h10;
    a.result = 16'h000f;
    run('0, a, '0, '0);
    chk("psw", 20'h1a, psw_o);
    a = '0;
    a.cy_src = CPR_CY_SHIFT;
    a.cy_in = 1'b1;
    run('0, a, '0, '0);
    chk("psw", 20'h1b, psw_o);
    $display("test flags done");
    s = '0;
    s.push = 1'b1;
    sq(s);
    chk("spbad", 20'h1, sp_bad_o);
    chk("sp", 20'h0, sp_o);
    bwr(20'hffff8, 8'h20);
    bwr(20'hffff9, 8'hfe);
    chk("sp", 20'hfe20, sp_o);
    s = '0;
    s.push = 1'b1;
    s.push_status = 1'b1;
    cpr_core_model_i.put(s, ka, '0, '0);
    chk("stk", 20'hffe1f, stk_adr_o);
    chk("save", 20'h1, save_psw_o);
    cpr_core_model_i.idle();
    chk("sp", 20'hfe1f, sp_o);
    s = '0;
    s.pop = 1'b1;
    sq(s);
    chk("sp", 20'hfe20, sp_o);
    rchk(20'hffff8, 8'h20);
    $display("test stack done");
    s = '0;
    s.bank_sw = 1'b1;
    sq(s);
    chk("psw", 20'h13, psw_o);
    g = '0;
    g.wr = 1'b1;
    g.w16 = 1'b1;
    g.wdata = 16'h1234;
    run('0, ka, g, '0);
    rchk(20'hffef8, 8'h34);
    rchk(20'hffef9, 8'h12);
    bwr(20'hffee0, 8'h5a);
    bwr(20'hffee1, 8'hc3);
    s.bank = 2'h3;
    sq(s);
    chk("psw", 20'h3b, psw_o);
    g = '0;
    g.r16 = 1'b1;
    run('0, ka, g, '0);
    chk("grd", 20'hc35a, grd_o);
    g.r16 = 1'b0;
    run('0, ka, g, '0);
    chk("grd", 20'h005a, grd_o);
    rchk(20'h00100, 8'h00);
    $display("test banks done");
    @(posedge clock_i);
    daddr_i <= 16'h1234;
    #1;
    chk("dadr", 20'hf1234, dadr_o);
    e = '0;
    e.es_wr = 1'b1;
    e.data = 4'h2;
    run('0, ka, '0, e);
    chk("es", 20'h2, es_o);
    @(posedge clock_i);
    use_es_i <= 1'b1;
    #1;
    chk("dadr", 20'h21234, dadr_o);
    rchk(20'hffffd, 8'h02);
    $display("test segments done");
    wrap_up();
  end
endmodule : cpu_processor_registers_tb_top
